// >>> core/scs_top.sv
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////
module scs_top
  import scs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       awvalid,
  output      logic       awready,
  input  wire logic [7:0] awaddr,
  input  wire logic       wvalid,
  output      logic       wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0] wstrb,
  output      logic       bvalid,
  input  wire logic       bready,
  output      logic [1:0] bresp,
  input  wire logic       arvalid,
  output      logic       arready,
  input  wire logic [7:0] araddr,
  output      logic       rvalid,
  input  wire logic       rready,
  output      logic [31:0] rdata,
  output      logic [1:0] rresp,
  input  wire logic       txck_i,
  output      logic       txck_o,
  output      logic       txck_oe,
  input  wire logic       rxdt_i,
  output      logic       rxdt_o,
  output      logic       rxdt_oe
);
  typedef enum logic {TX_IDLE, TX_SHIFT} scs_tx_e;
  typedef enum logic {RX_IDLE, RX_SHIFT} scs_rx_e;

  ////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]  txcs_ff;   // transmit control/status
  logic [7:0]  rxcs_ff;   // receive control, status bits apart
  logic [7:0]  baud_ff;   // baud control writable bits
  logic [7:0]  divl_ff;   // divisor low byte
  logic [7:0]  divh_ff;   // divisor high byte
  logic        abdovf_ff; // auto-baud overflow
  logic        abd_run_ff; // measuring a low pulse
  logic [15:0] abd_cnt_ff; // pulse length in cycles
  logic        oerr_ff;   // overrun
  logic        aw_ff;     // write address held
  logic [7:0]  awa_ff;    // held write address
  logic        w_ff;      // write data held
  logic [7:0]  wd_ff;     // held write byte
  logic        ws_ff;     // low lane strobe held
  logic        bvalid_ff; // write answer
  logic [1:0]  bresp_ff;  // write answer code
  logic        rvalid_ff; // read answer
  logic [1:0]  rresp_ff;  // read answer code
  logic [31:0] rdata_ff;  // read answer data
  logic        rxs1_ff;   // data pin first stage
  logic        rxs2_ff;   // data pin second stage
  logic        rxs3_ff;   // data pin delayed
  logic        cks1_ff;   // clock pin first stage
  logic        cks2_ff;   // clock pin second stage
  logic        cks3_ff;   // clock pin delayed
  logic [15:0] brg_ff;    // baud counter
  logic        ck_ff;     // master sync clock
  scs_tx_e     tx_st_ff;  // transmit state
  logic [13:0] tsr_ff;    // transmit shift register
  logic [3:0]  tx_left_ff; // bits left to send
  logic [3:0]  tx_os_ff;  // transmit oversample phase
  logic        tx_brk_ff; // break in progress
  scs_rx_e     rx_st_ff;  // receive state
  logic [8:0]  rsr_ff;    // receive shift register
  logic [3:0]  rx_left_ff; // bits left to take
  logic [3:0]  rx_os_ff;  // receive oversample phase
  logic        push_ff;   // character to buffer
  logic [9:0]  pdat_ff;   // character and status
  logic        txck_o_ff; // pin drive values
  logic        txck_oe_ff;
  logic        rxdt_o_ff;
  logic        rxdt_oe_ff;
  logic        sync_m, port_enable, master, rx_sync_req;
  logic        tx_en, rx_on, tick, ck_rise, ck_fall;
  logic        tx_step, rx_samp, rxd, tx_done, single_receive_enable_clr;
  logic [3:0]  os_max, tx_len, rx_len;
  logic [15:0] div, nxt_abd_div;
  logic        do_wr, wr_en, rd_take, wr_map, rd_map, pop;
  logic [7:0]  rd_mux;
  scs_fifo_if #(.W(FIFO_W)) rxq ();

  ////////////////////////////////////////////////////////////////////
  // decoded controls
  assign sync_m = txcs_ff[B_SYNC];
  assign port_enable   = rxcs_ff[B_PORT_ENABLE];
  assign master = sync_m & txcs_ff[B_CLOCK_SOURCE_SELECT];
  assign rx_sync_req = sync_m & (rxcs_ff[B_SINGLE_RECEIVE_ENABLE] | rxcs_ff[B_CONTINUOUS_RECEIVE_ENABLE]);
  // receive request in sync mode turns the transmitter off
  assign tx_en = port_enable & txcs_ff[B_TRANSMITTER_ENABLE_BIT] & ~rx_sync_req;
  // async takes characters only with continuous enable
  assign rx_on = port_enable & ~oerr_ff & ~baud_ff[B_ABD] &
                 (sync_m ? rx_sync_req : rxcs_ff[B_CONTINUOUS_RECEIVE_ENABLE]);
  // high speed is a short oversample, async only
  assign os_max = (txcs_ff[B_HIGH_SPEED_BAUD_SELECT] & ~sync_m) ? OS_HIGH : OS_LOW;
  assign div = baud_ff[B_B16] ? {divh_ff, divl_ff}
                              : {8'h00, divl_ff};
  assign tx_len = txcs_ff[B_TX9] ? LEN9 : LEN8;
  assign rx_len = rxcs_ff[B_RX9] ? LEN9 : LEN8;
  assign rxd  = rxs2_ff;
  assign tick = brg_ff == 16'h0000;
  // master edges come from the generator, slave edges from the pin
  assign ck_rise = master ? (tick & ~ck_ff) : (cks2_ff & ~cks3_ff);
  assign ck_fall = master ? (tick & ck_ff) : (~cks2_ff & cks3_ff);
  assign tx_step = sync_m ? ck_fall : (tick & (tx_os_ff == os_max));
  assign rx_samp = sync_m ? ck_rise
                          : (tick & (rx_os_ff == {1'b0, os_max[3:1]}));
  assign tx_done = (tx_st_ff == TX_SHIFT) & tx_step & (tx_left_ff == 4'h1);
  assign single_receive_enable_clr = sync_m & master & rx_samp & (rx_left_ff == 4'h1) &
                    (rx_st_ff == RX_SHIFT) & ~rxcs_ff[B_CONTINUOUS_RECEIVE_ENABLE];
  assign nxt_abd_div = (abd_cnt_ff >> (txcs_ff[B_HIGH_SPEED_BAUD_SELECT] ? ABD_SH_HIGH
                                                       : ABD_SH_LOW))
                       - 16'h0001;

  ////////////////////////////////////////////////////////////////////
  // bus slave
  assign awready = ~aw_ff;
  assign wready  = ~w_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = ~rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rresp   = rresp_ff;
  assign rdata   = rdata_ff;
  assign do_wr   = aw_ff & w_ff & ~bvalid_ff;
  assign wr_en   = do_wr & ws_ff & wr_map;
  assign rd_take = arvalid & ~rvalid_ff;
  // reading the data register removes the oldest character
  assign pop = rd_take & (araddr == OFS_RXDAT) & rxq.out_valid;

  // address map check
  always_comb begin
    wr_map = (awa_ff <= OFS_TXDAT) & (awa_ff[1:0] == 2'b00) &
             (awa_ff != OFS_RXDAT);
    rd_map = (araddr <= OFS_TXDAT) & (araddr[1:0] == 2'b00);
  end

  // read data select
  always_comb begin
    unique case (araddr)
      OFS_TXCS:  rd_mux = {txcs_ff[7:2], tx_st_ff == TX_IDLE,
                           txcs_ff[0]};
      // empty buffer shows no stale status from an old slot
      OFS_RXCS:  rd_mux = {rxcs_ff[7:3],
                           rxq.out_valid & rxq.out_data[9], oerr_ff,
                           rxq.out_valid & rxq.out_data[8]};
      OFS_BAUD:  rd_mux = {abdovf_ff, rx_st_ff == RX_IDLE, 1'b0,
                           baud_ff[4:3], 1'b0, baud_ff[1:0]};
      OFS_DIVL:  rd_mux = divl_ff;
      OFS_DIVH:  rd_mux = divh_ff;
      OFS_RXDAT: rd_mux = rxq.out_data[7:0];
      default:   rd_mux = 8'h00;
    endcase
  end

  // write address and data capture, either order
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_ff  <= 1'b0;
      awa_ff <= 8'h00;
      w_ff   <= 1'b0;
      wd_ff  <= 8'h00;
      ws_ff  <= 1'b0;
    end else if (ce) begin
      if (awvalid && !aw_ff) begin
        aw_ff  <= 1'b1;
        awa_ff <= awaddr;
      end else if (do_wr) begin
        aw_ff  <= 1'b0;
      end
      if (wvalid && !w_ff) begin
        w_ff  <= 1'b1;
        wd_ff <= wdata[7:0];
        ws_ff <= wstrb[0];
      end else if (do_wr) begin
        w_ff  <= 1'b0;
      end
    end
  end

  // write and read answers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (ce) begin
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
      if (rd_take) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        rdata_ff  <= {24'h000000, rd_mux};
      end else if (rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control registers
  // transmit control; a software set of break wins over the clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txcs_ff <= TXCS_RST;
    end else if (ce) begin
      if (tx_done && tx_brk_ff) txcs_ff[B_SNDB] <= 1'b0;
      if (wr_en && awa_ff == OFS_TXCS) begin
        txcs_ff <= {wd_ff[7:2], 1'b0, wd_ff[0]};
      end
    end
  end

  // receive control; single receive ends itself in master mode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxcs_ff <= RXCS_RST;
    end else if (ce) begin
      if (single_receive_enable_clr) rxcs_ff[B_SINGLE_RECEIVE_ENABLE] <= 1'b0;
      if (wr_en && awa_ff == OFS_RXCS) begin
        rxcs_ff <= {wd_ff[7:3], 3'b000};
      end
    end
  end

  // baud control, divisor bytes and auto-baud measurement
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_ff    <= BAUD_RST;
      divl_ff    <= DIV_RST;
      divh_ff    <= DIV_RST;
      abdovf_ff  <= 1'b0;
      abd_run_ff <= 1'b0;
      abd_cnt_ff <= 16'h0000;
    end else if (ce) begin
      if (baud_ff[B_ABD] && port_enable && !sync_m) begin
        // time one low bit on the line
        if (!abd_run_ff && !rxd && rxs3_ff) begin
          abd_run_ff <= 1'b1;
          abd_cnt_ff <= 16'h0001; // first low cycle counts
        end else if (abd_run_ff && rxd) begin
          abd_run_ff <= 1'b0;
          baud_ff[B_ABD] <= 1'b0;
          {divh_ff, divl_ff} <= nxt_abd_div;
        end else if (abd_run_ff && abd_cnt_ff == 16'hffff) begin
          abd_run_ff <= 1'b0;
          baud_ff[B_ABD] <= 1'b0;
          abdovf_ff <= 1'b1;
        end else if (abd_run_ff) begin
          abd_cnt_ff <= abd_cnt_ff + 16'h0001;
        end
      end else begin
        abd_run_ff <= 1'b0;
      end
      if (wr_en) begin
        unique case (awa_ff)
          OFS_BAUD: begin
            baud_ff <= {3'b000, wd_ff[4:3], 1'b0, wd_ff[1:0]};
            if (wd_ff[B_ABD]) abdovf_ff <= 1'b0;
          end
          OFS_DIVL: divl_ff <= wd_ff;
          OFS_DIVH: divh_ff <= wd_ff;
          default: ;
        endcase
      end
    end
  end

  // overrun: set when the buffer refuses, cleared while continuous receive or the port is off
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      oerr_ff <= 1'b0;
    end else if (ce) begin
      if (push_ff && !rxq.in_ready) oerr_ff <= 1'b1;
      else if (!rxcs_ff[B_CONTINUOUS_RECEIVE_ENABLE] || !port_enable) oerr_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {rxs1_ff, rxs2_ff, rxs3_ff} <= 3'b111;
      {cks1_ff, cks2_ff, cks3_ff} <= 3'b000;
    end else if (ce) begin
      {rxs1_ff, rxs2_ff, rxs3_ff} <= {rxdt_i, rxs1_ff, rxs2_ff};
      {cks1_ff, cks2_ff, cks3_ff} <= {txck_i, cks1_ff, cks2_ff};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // baud generator and master clock; port disable holds it in reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      brg_ff <= 16'h0000;
      ck_ff  <= 1'b0;
    end else if (ce) begin
      if (!port_enable) begin
        brg_ff <= 16'h0000;
        ck_ff  <= 1'b0;
      end else begin
        brg_ff <= tick ? div : brg_ff - 16'h0001;
        if (master && tick &&
            (tx_st_ff == TX_SHIFT || rx_st_ff == RX_SHIFT)) begin
          ck_ff <= ~ck_ff;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmitter; a write to the data offset loads an idle shifter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_ff   <= TX_IDLE;
      tsr_ff     <= 14'h3fff;
      tx_left_ff <= 4'h0;
      tx_os_ff   <= 4'h0;
      tx_brk_ff  <= 1'b0;
    end else if (ce) begin
      if (tick) tx_os_ff <= (tx_os_ff == os_max) ? 4'h0 : tx_os_ff + 4'h1;
      unique case (tx_st_ff)
        TX_IDLE: begin
          if (tx_en && wr_en && awa_ff == OFS_TXDAT) begin
            tx_st_ff <= TX_SHIFT;
            tx_os_ff <= 4'h0;
            if (sync_m) begin
              tsr_ff     <= {5'h1f, txcs_ff[B_TRANSMIT_NINTH_BIT], wd_ff};
              tx_left_ff <= tx_len;
              tx_brk_ff  <= 1'b0;
            end else if (txcs_ff[B_SNDB]) begin
              // break: start plus twelve low bits, then stop
              tsr_ff     <= {1'b1, 13'h0000};
              tx_left_ff <= BRK_LEN;
              tx_brk_ff  <= 1'b1;
            end else begin
              tsr_ff <= {4'hf, txcs_ff[B_TX9] ? txcs_ff[B_TRANSMIT_NINTH_BIT] : 1'b1,
                         wd_ff, 1'b0};
              tx_left_ff <= tx_len + 4'h2;
              tx_brk_ff  <= 1'b0;
            end
          end
        end
        TX_SHIFT: begin
          if (!tx_en || tx_done) begin
            tx_st_ff  <= TX_IDLE;
            tsr_ff    <= 14'h3fff;
            tx_brk_ff <= 1'b0;
          end else if (tx_step) begin
            tsr_ff     <= {1'b1, tsr_ff[13:1]};
            tx_left_ff <= tx_left_ff - 4'h1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receiver
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_ff   <= RX_IDLE;
      rsr_ff     <= 9'h000;
      rx_left_ff <= 4'h0;
      rx_os_ff   <= 4'h0;
      push_ff    <= 1'b0;
      pdat_ff    <= 10'h000;
    end else if (ce) begin
      push_ff <= 1'b0;
      if (tick) rx_os_ff <= (rx_os_ff == os_max) ? 4'h0 : rx_os_ff + 4'h1;
      unique case (rx_st_ff)
        RX_IDLE: begin
          if (rx_on && (sync_m || !rxd)) begin
            rx_st_ff   <= RX_SHIFT;
            rx_os_ff   <= 4'h0;
            rx_left_ff <= sync_m ? rx_len : rx_len + 4'h2;
          end
        end
        RX_SHIFT: begin
          if (!rx_on) begin
            rx_st_ff <= RX_IDLE;
          end else if (rx_samp) begin
            rx_left_ff <= rx_left_ff - 4'h1;
            if (!sync_m && rx_left_ff == rx_len + 4'h2 && rxd) begin
              rx_st_ff <= RX_IDLE;                       // false start
            end else if (!sync_m && rx_left_ff == 4'h1) begin
              // stop bit: a low level marks a framing error
              rx_st_ff <= RX_IDLE;
              push_ff  <= ~(rxcs_ff[B_RX9] & rxcs_ff[B_ADDN]) | rsr_ff[8];
              pdat_ff  <= {~rxd, rxcs_ff[B_RX9] ? rsr_ff
                                                : {1'b0, rsr_ff[8:1]}};
            end else if (sync_m && rx_left_ff == 4'h1) begin
              push_ff  <= 1'b1;
              pdat_ff  <= {1'b0, rxcs_ff[B_RX9] ? {rxd, rsr_ff[8:1]}
                                                : {1'b0, rxd, rsr_ff[8:2]}};
              rx_left_ff <= rx_len;
              if (!rxcs_ff[B_CONTINUOUS_RECEIVE_ENABLE]) rx_st_ff <= RX_IDLE;
            end else if (sync_m || rx_left_ff != rx_len + 4'h2) begin
              rsr_ff <= {rxd, rsr_ff[8:1]};
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive buffer; disabling the port empties it and clears ferr
  assign rxq.in_valid  = push_ff;
  assign rxq.in_data   = pdat_ff;
  assign rxq.out_ready = pop;

  scs_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_rxq (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .flush    (~port_enable),
    .q        (rxq.fifo)
  );

  ////////////////////////////////////////////////////////////////////
  // pin drivers, registered
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txck_o_ff  <= 1'b1;
      txck_oe_ff <= 1'b0;
      rxdt_o_ff  <= 1'b1;
      rxdt_oe_ff <= 1'b0;
    end else if (ce) begin
      txck_o_ff  <= sync_m ? ck_ff : tsr_ff[0];
      txck_oe_ff <= port_enable & (~sync_m | master);
      rxdt_o_ff  <= tsr_ff[0];
      rxdt_oe_ff <= port_enable & sync_m & tx_en;
    end
  end

  assign txck_o  = txck_o_ff;
  assign txck_oe = txck_oe_ff;
  assign rxdt_o  = rxdt_o_ff;
  assign rxdt_oe = rxdt_oe_ff;
endmodule : scs_top

// >>> core/scs_pkg.sv
package scs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_TXCS  = 8'h00;
  localparam logic [7:0] OFS_RXCS  = 8'h04;
  localparam logic [7:0] OFS_BAUD  = 8'h08;
  localparam logic [7:0] OFS_DIVL  = 8'h0c;
  localparam logic [7:0] OFS_DIVH  = 8'h10;
  localparam logic [7:0] OFS_RXDAT = 8'h14;
  localparam logic [7:0] OFS_TXDAT = 8'h18;
  // transmit_control_status fields
  localparam int B_CLOCK_SOURCE_SELECT = 7;
  localparam int B_TX9  = 6;
  localparam int B_TRANSMITTER_ENABLE_BIT = 5;
  localparam int B_SYNC = 4;
  localparam int B_SNDB = 3;
  localparam int B_HIGH_SPEED_BAUD_SELECT = 2;
  localparam int B_TRANSMIT_NINTH_BIT = 0;
  // receive_control_status fields
  localparam int B_PORT_ENABLE = 7;
  localparam int B_RX9  = 6;
  localparam int B_SINGLE_RECEIVE_ENABLE = 5;
  localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int B_ADDN = 3;
  // baud_control fields
  localparam int B_SCKP = 4;
  localparam int B_B16  = 3;
  localparam int B_WUE  = 1;
  localparam int B_ABD  = 0;
  // values after reset
  localparam logic [7:0] TXCS_RST = 8'h00;
  localparam logic [7:0] RXCS_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] DIV_RST  = 8'h00;
  // oversample wrap counts per bit, low and high speed
  localparam logic [3:0] OS_LOW  = 4'hf;
  localparam logic [3:0] OS_HIGH = 4'h3;
  // frame lengths in bits
  localparam logic [3:0] LEN8    = 4'h8;
  localparam logic [3:0] LEN9    = 4'h9;
  localparam logic [3:0] BRK_LEN = 4'he;
  // shift amounts for auto-baud divide
  localparam logic [3:0] ABD_SH_LOW  = 4'h4;
  localparam logic [3:0] ABD_SH_HIGH = 4'h2;
  // receive buffer shape: ferr, ninth bit, eight data bits
  localparam int FIFO_W     = 10;
  localparam int FIFO_DEPTH = 4;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : scs_pkg

// >>> core/scs_fifo_if.sv
`timescale 1ns/1ns
// receive buffer handshake between the port core and its fifo
interface scs_fifo_if #(parameter int W = 10);
  logic         in_valid;  // character offered
  logic         in_ready;  // room for it
  logic [W-1:0] in_data;   // character with status
  logic         out_valid; // oldest character present
  logic         out_ready; // remove the oldest
  logic [W-1:0] out_data;  // oldest character
  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface : scs_fifo_if

// >>> core/scs_fifo.sv
`timescale 1ns/1ns
module scs_fifo
  import scs_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_DEPTH
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic flush,
  scs_fifo_if.fifo q
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);
  logic [W-1:0]  mem_ff [D]; // storage words
  logic [AW-1:0] wp_ff;      // write pointer
  logic [AW-1:0] rp_ff;      // read pointer
  logic [AW:0]   cnt_ff;     // words held
  logic          push;
  logic          pop;

  assign q.in_ready  = cnt_ff != FULL;
  assign q.out_valid = cnt_ff != '0;
  assign q.out_data  = mem_ff[rp_ff];
  assign push = q.in_valid & q.in_ready;
  assign pop  = q.out_valid & q.out_ready;

  // storage write, no reset needed for data
  always_ff @(posedge core_clk) begin
    if (ce && push) begin
      mem_ff[wp_ff] <= q.in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else if (ce) begin
      if (flush) begin
        wp_ff  <= '0;
        rp_ff  <= '0;
        cnt_ff <= '0;
      end else begin
        if (push) wp_ff <= wp_ff + 1'b1;
        if (pop)  rp_ff <= rp_ff + 1'b1;
        cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule : scs_fifo

// >>> tb/scs_props.sv
`timescale 1ns/1ns
// bus handshake checks seen from the top ports
module scs_props (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_aw_held: assert property (awvalid && awready |=> !awready)
    else $error("address taken but still ready");
  a_w_held: assert property (wvalid && wready |=> !wready)
    else $error("data taken but still ready");
  a_b_follow: assert property (awvalid && awready && wvalid && wready && !bvalid
    |=> !bvalid ##1 bvalid) else $error("write answer late");
  a_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_b_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  a_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_r_upper: assert property (rvalid |-> rdata[31:8] == 24'h0 && !arready)
    else $error("read word malformed");
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
  c_error: cover property (bvalid && bresp == 2'h2);
endmodule : scs_props
bind scs_top scs_props i_props (.*);

// >>> tb/scs_line_model.sv
`timescale 1ns/1ns
// far end of the serial line: samples our frames, sends its own
module scs_line_model (
  input  wire logic core_clk,
  input  wire logic tx_line,
  output logic      rx_line
);
  int          bt = 4;     // bit time in clock cycles
  int          nb = 8;     // data bits per frame
  int          frames = 0; // frames seen
  logic [15:0] got;        // last frame, stop bit on top
  initial rx_line = 1'b1;  // line idles high
  // start bit seen: sample each bit in its middle
  always begin
    @(negedge tx_line);
    got = '0;
    repeat (bt / 2) @(posedge core_clk);
    for (int i = 0; i <= nb; i++) begin
      repeat (bt) @(posedge core_clk);
      got[i] = tx_line;
    end
    frames++;
  end
  // one frame: start, n bits lsb first, stop
  task automatic send(input logic [8:0] d, input int n);
    rx_line <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (bt) @(posedge core_clk);
      rx_line <= (i == n) ? 1'b1 : d[i];
    end
    repeat (2 * bt) @(posedge core_clk); // long stop lets the buffer fill
  endtask : send
endmodule : scs_line_model

// >>> tb/serial_port_control_status_test.sv
`timescale 1ns/1ns
module serial_port_control_status_test;
  import scs_pkg::*;
  logic core_clk = 0, arst_n = 0, ce = 1, txck_i = 1, rxdt_i;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, v;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'h1;
  logic awready, wready, bvalid, arready, rvalid, txck_o, txck_oe;
  logic rxdt_o, rxdt_oe;
  logic [1:0] bresp, rresp;
  logic [15:0] sr = 16'd70; // random source state
  logic [7:0] q[$];         // characters sent to the port
  int fails = 0, compares = 0;
  scs_top i_dut (.*);
  scs_line_model i_line (.core_clk, .tx_line(txck_o), .rx_line(rxdt_i));
  initial forever #4 core_clk = ~core_clk;
  // hang guard
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  function automatic logic [7:0] rnd();
    sr = {sr[14:0], sr[15] ^ sr[13] ^ sr[12] ^ sr[10]};
    return sr[7:0];
  endfunction : rnd
  // expected line frame: data then stop bit
  function automatic logic [15:0] frame(input logic [8:0] d, input int n);
    return (16'h1 << n) | {7'h0, d};
  endfunction : frame
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  // bus write; sampled mid cycle, released at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic [2:0] h;
    logic [1:0] r;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge core_clk);
      h = {awvalid & awready, wvalid & wready, bvalid};
      r = bresp;
      @(posedge core_clk);
      if (h[2]) awvalid <= 1'b0;
      if (h[1]) wvalid <= 1'b0;
    end while (!h[0]);
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
    @(posedge core_clk);
  endtask : wr
  // bus read and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] er = RESP_OKAY);
    logic t, g;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge core_clk);
      t = arvalid & arready;
      g = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (t) arvalid <= 1'b0;
    end while (!g);
    rready <= 1'b0;
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, er});
    @(posedge core_clk);
  endtask : rc
  task automatic print_verdict();
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rc(OFS_TXCS, 8'h02);
    rc(8'h1c, 8'h00, RESP_SLVERR);
    wr(OFS_RXDAT, 8'h5a, RESP_SLVERR);
    v = rnd();
    wr(OFS_DIVL, v);
    rc(OFS_DIVL, v);
    v = rnd();
    wr(OFS_DIVH, v);
    rc(OFS_DIVH, v);
    wr(OFS_DIVH, 8'h00);
    wr(OFS_DIVL, 8'h00);
    wr(OFS_RXCS, 8'h90);
    wr(OFS_TXDAT, rnd());
    repeat (60) @(posedge core_clk);
    chk(i_line.frames, 0);
    // 8-bit then 9-bit frames, fast rate
    for (int n = 8; n <= 9; n++) begin
      wr(OFS_TXCS, (n == 9) ? 8'h65 : 8'h24);
      i_line.nb = n;
      v = rnd();
      wr(OFS_TXDAT, v);
      rc(OFS_TXCS, (n == 9) ? 8'h65 : 8'h24);
      repeat (60) @(posedge core_clk);
      chk(i_line.got, frame({n == 9, v}, n));
      rc(OFS_TXCS, (n == 9) ? 8'h67 : 8'h26);
    end
    i_line.nb = 8;
    wr(OFS_TXCS, 8'h2c);
    wr(OFS_TXDAT, rnd());
    repeat (80) @(posedge core_clk);
    chk(i_line.got, 16'h0);
    rc(OFS_TXCS, 8'h26);
    repeat (3) begin
      v = rnd();
      q.push_back(v);
      i_line.send({1'b0, v}, 8);
    end
    rc(OFS_RXCS, 8'h90);
    repeat (3) rc(OFS_RXDAT, q.pop_front());
    wr(OFS_RXCS, 8'hd0);
    v = rnd();
    i_line.send({1'b1, v}, 9);
    rc(OFS_RXCS, 8'hd1);
    rc(OFS_RXDAT, v);
    // auto-baud: eight low bits of four cycles give divisor 7
    wr(OFS_BAUD, 8'h01);
    i_line.send({1'b0, 8'h80}, 8);
    rc(OFS_DIVL, 8'h07);
    rc(OFS_BAUD, 8'h40);
    // sync master drives clock; receive enable wins over transmit
    wr(OFS_TXCS, 8'hb0);
    wr(OFS_RXCS, 8'h80);
    chk({txck_oe, rxdt_oe}, 2'b11);
    wr(OFS_RXCS, 8'h90);
    chk({txck_oe, rxdt_oe}, 2'b10);
    wr(OFS_TXCS, 8'h30);
    chk(txck_oe, 1'b0);
    wr(OFS_RXCS, 8'h00);
    rc(OFS_RXCS, 8'h00);
    chk({txck_oe, rxdt_oe}, 2'b00);
    print_verdict();
  end
endmodule : serial_port_control_status_test
